// ===== cmsc_clock_mode_select.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// (R1) Bit 7 picks oscillator drive, 0 low power and 1 high gain.
// (R2) The gain bit takes only the first write after reset and holds it.
// (R3) Any write-once bit ignores every write after its first since reset.
// (R4) Bit 6 picks the range, 0 low with prescale 64 and 1 high with prescale 1.
// (R5) The range bit is writable once after reset.
// (R6) The range only affects clocking in the two external reference modes.
// (R7) Bit 5 picks the reference, 0 external clock and 1 crystal oscillator.
// (R8) The reference select bit is writable once after reset.
// (R9) Bits 4:3 hold the mode: self-clocked, loop internal, bypass external, loop external.
// (R10) Bypass external mode waits for external reference ready before switching.
// (R11) Entering off mode leaves the stored mode field unchanged.
// (R12) Mode writes are ignored while a previous mode change is in progress.
// (R13) A first mode write of an internal mode refuses external modes until reset.
// (R14) Sticky per-bit written flags and a first-mode-write flag are cleared only by reset.
module cmsc_clock_mode_select (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cmsc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic external_reference_ready,
	input wire logic fll_locked,
	input wire logic gen_off,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic high_gain_select,
	output logic range_high,
	output logic [6:0] loop_prescale,
	output logic reference_source_select,
	output logic [1:0] active_mode,
	output logic gen_running
);
	import cmsc_pkg::*;

	function automatic logic is_ext(input logic [1:0] m);
		is_ext = m[1];
	endfunction : is_ext

	logic wr_acc;
	logic ctrl_wr;
	logic [7:0] wbyte;
	logic gain_q, gain_done_q;
	logic range_q, range_done_q;
	logic reference_source_select_q, reference_source_select_done_q;
	logic [1:0] mode_field_q;
	logic mode_first_done_q;
	logic ext_lock_q;
	logic mode_wr_ok;
	logic busy;
	cmsc_mode_t active;
	cmsc_mode_t req_mode;
	logic [7:0] ctrl_rd;
	logic [7:0] stat_rd;

	// one wait state: setup, access, answer
	assign wr_acc = psel && penable && pready && pwrite;
	assign ctrl_wr = wr_acc && (paddr == CTRL_ONE_OFS) && pstrb[0];
	assign wbyte = pwdata[7:0];
	assign req_mode = cmsc_mode_t'(wbyte[MODE_HI:MODE_LO]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	cmsc_once_bit u_gain (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(ctrl_wr), // (R2) (R3)
		.wr_val(wbyte[GAIN_BIT]), // (R1)
		.val_q(gain_q),
		.done_q(gain_done_q)
	);
	cmsc_once_bit u_range (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(ctrl_wr), // (R5) (R3)
		.wr_val(wbyte[RANGE_BIT]), // (R4)
		.val_q(range_q),
		.done_q(range_done_q)
	);
	cmsc_once_bit u_reference_source_select (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(ctrl_wr), // (R8) (R3)
		.wr_val(wbyte[REFERENCE_SOURCE_SELECT_BIT]), // (R7)
		.val_q(reference_source_select_q),
		.done_q(reference_source_select_done_q)
	);

	// mode write accepted unless busy or locked out
	assign mode_wr_ok = ctrl_wr && !busy && !(ext_lock_q && is_ext(req_mode)); // (R12) (R13)

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_first_done_q <= 1'b0;
			ext_lock_q <= 1'b0;
		end else if (ctrl_wr && !mode_first_done_q) begin
			mode_first_done_q <= 1'b1; // (R14)
			ext_lock_q <= !is_ext(req_mode); // (R13)
		end
	end

	// off mode never touches the stored field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_field_q <= CTRL_ONE_RST[MODE_HI:MODE_LO];
		end else if (mode_wr_ok) begin
			mode_field_q <= wbyte[MODE_HI:MODE_LO]; // (R9) (R11)
		end
	end

	cmsc_mode_seq u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.req_valid(mode_wr_ok),
		.req_mode(req_mode),
		.ext_ready(external_reference_ready),
		.fll_locked(fll_locked),
		.active_q(active),
		.busy_q(busy)
	);

	assign ctrl_rd = {gain_q, range_q, reference_source_select_q, mode_field_q, 3'h0};
	assign stat_rd = {gain_done_q, range_done_q, reference_source_select_done_q, ext_lock_q,
		gen_off, busy, active};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			if (paddr == CTRL_ONE_OFS) begin
				prdata <= {24'h00_0000, ctrl_rd};
			end else if (paddr == STATUS_OFS) begin
				prdata <= {24'h00_0000, stat_rd};
			end else begin
				prdata <= PSLVERR_NONE;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && penable && !pready && (paddr != CTRL_ONE_OFS) && (paddr != STATUS_OFS);
		end
	end

	// outputs to the clock generator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_gain_select <= 1'b0;
		end else begin
			high_gain_select <= gain_q; // (R1)
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_source_select <= 1'b0;
		end else begin
			reference_source_select <= reference_source_select_q; // (R7)
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_mode <= CMSC_SELF;
		end else begin
			active_mode <= active; // (R9)
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_running <= 1'b0;
		end else begin
			gen_running <= !gen_off;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_high <= 1'b0;
			loop_prescale <= PRESCALE_HIGH;
		end else if (is_ext(active)) begin
			range_high <= range_q; // (R6)
			loop_prescale <= range_q ? PRESCALE_HIGH : PRESCALE_LOW; // (R4)
		end else begin
			range_high <= 1'b0; // (R6)
			loop_prescale <= PRESCALE_HIGH;
		end
	end

	sequence s_ctrl_read;
		psel && penable && !pready && !pwrite && (paddr == CTRL_ONE_OFS) ##1 pready;
	endsequence
	sequence s_stat_read;
		psel && penable && !pready && !pwrite && (paddr == STATUS_OFS) ##1 pready;
	endsequence

	a_mode_busy_block: assert property (@(posedge pclk) disable iff (!presetn) // (R12)
		(ctrl_wr && busy) |=> mode_field_q == $past(mode_field_q))
		else $error("mode written while change pending");
	a_ext_lockout: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
		ext_lock_q |-> !is_ext(mode_field_q))
		else $error("external mode stored after internal first write");
	a_gain_once: assert property (@(posedge pclk) disable iff (!presetn) // (R2)
		(ctrl_wr && gain_done_q) |=> gain_q == $past(gain_q))
		else $error("gain bit rewritten");
	a_range_once: assert property (@(posedge pclk) disable iff (!presetn) // (R5)
		(ctrl_wr && range_done_q) |=> range_q == $past(range_q))
		else $error("range bit rewritten");
	a_reference_source_select_once: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
		(ctrl_wr && reference_source_select_done_q) |=> reference_source_select_q == $past(reference_source_select_q))
		else $error("reference bit rewritten");
	a_range_effect: assert property (@(posedge pclk) disable iff (!presetn) // (R6)
		!is_ext(active) |=> (loop_prescale == PRESCALE_HIGH) && !range_high)
		else $error("range acted in internal mode");
	a_prescale_low: assert property (@(posedge pclk) disable iff (!presetn) // (R4)
		(is_ext(active) && !range_q) |=> loop_prescale == PRESCALE_LOW)
		else $error("low range prescale wrong");
	a_off_keeps: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
		($rose(gen_off) && !mode_wr_ok) |=> $stable(mode_field_q))
		else $error("off mode changed mode field");
	a_first_flag: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
		ctrl_wr |=> mode_first_done_q && gain_done_q)
		else $error("written flags not set");
	a_gain_first: assert property (@(posedge pclk) disable iff (!presetn) // (R2)
		(ctrl_wr && !gain_done_q) |=> gain_q == $past(wbyte[GAIN_BIT]))
		else $error("first gain write not taken");
	a_range_first: assert property (@(posedge pclk) disable iff (!presetn) // (R5)
		(ctrl_wr && !range_done_q) |=> range_q == $past(wbyte[RANGE_BIT]))
		else $error("first range write not taken");
	a_reference_source_select_first: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
		(ctrl_wr && !reference_source_select_done_q) |=> reference_source_select_q == $past(wbyte[REFERENCE_SOURCE_SELECT_BIT]))
		else $error("first reference write not taken");
	a_gain_sticky: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
		gain_done_q |=> gain_done_q)
		else $error("gain written flag dropped");
	a_reference_source_select_sticky: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
		reference_source_select_done_q |=> reference_source_select_done_q)
		else $error("reference written flag dropped");
	a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
		ext_lock_q |=> ext_lock_q)
		else $error("external lockout dropped");
	a_first_sticky: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
		mode_first_done_q |=> mode_first_done_q)
		else $error("first mode write flag dropped");
	a_gain_drive: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
		gain_done_q |=> high_gain_select == $past(gain_q))
		else $error("gain output does not follow bit");
	a_reference_source_select_drive: assert property (@(posedge pclk) disable iff (!presetn) // (R7)
		reference_source_select_done_q |=> reference_source_select == $past(reference_source_select_q))
		else $error("reference output does not follow bit");
	a_mode_drive: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
		mode_first_done_q |=> active_mode == $past(active))
		else $error("mode output does not follow active mode");
	a_range_high: assert property (@(posedge pclk) disable iff (!presetn) // (R4)
		(is_ext(active) && range_q) |=> range_high && (loop_prescale == PRESCALE_HIGH))
		else $error("high range prescale wrong");
	a_range_pass: assert property (@(posedge pclk) disable iff (!presetn) // (R6)
		is_ext(active) |=> range_high == $past(range_q))
		else $error("range not applied in external mode");
	a_mode_accept: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
		mode_wr_ok |=> mode_field_q == $past(wbyte[MODE_HI:MODE_LO]))
		else $error("accepted mode write not stored");
	a_lock_refuse: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
		(ctrl_wr && ext_lock_q && wbyte[MODE_HI]) |=> $stable(mode_field_q))
		else $error("external mode write not refused");
	a_lock_set: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
		(ctrl_wr && !mode_first_done_q && !wbyte[MODE_HI]) |=> ext_lock_q)
		else $error("internal first write did not lock");
	a_no_lock_ext: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
		(ctrl_wr && !mode_first_done_q && wbyte[MODE_HI]) |=> !ext_lock_q)
		else $error("external first write locked out");
	a_busy_set: assert property (@(posedge pclk) disable iff (!presetn) // (R12)
		(mode_wr_ok && (req_mode != active)) |=> busy)
		else $error("mode change not marked pending");
	a_off_running: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
		gen_off |=> !gen_running)
		else $error("running shown while off");
	a_active_stable: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
		!busy |=> $stable(active))
		else $error("clock source moved with no pending change");
	a_bypass_ready: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
		($changed(active) && (active == CMSC_BYP_EXT)) |-> $past(external_reference_ready))
		else $error("bypass taken without reference ready");
	a_fll_ext_ready: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
		($changed(active) && (active == CMSC_FLL_EXT)) |-> $past(external_reference_ready) && $past(fll_locked))
		else $error("external loop taken before ready");
	a_ctrl_readback: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
		s_ctrl_read |-> prdata == {24'h00_0000, $past(ctrl_rd)})
		else $error("control read data wrong");
	a_stat_readback: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
		s_stat_read |-> prdata == {24'h00_0000, $past(stat_rd)})
		else $error("status read data wrong");
endmodule : cmsc_clock_mode_select

// ===== cmsc_pkg.sv
package cmsc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_ONE_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
	localparam int GAIN_BIT = 7;
	localparam int RANGE_BIT = 6;
	localparam int REFERENCE_SOURCE_SELECT_BIT = 5;
	localparam int MODE_HI = 4;
	localparam int MODE_LO = 3;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [6:0] PRESCALE_LOW = 7'h40;
	localparam logic [6:0] PRESCALE_HIGH = 7'h01;
	localparam int ST_ACTIVE_LO = 0;
	localparam int ST_ACTIVE_HI = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_OFF = 3;
	localparam int ST_XLOCK = 4;
	localparam int ST_WR_HGO = 5;
	localparam int ST_WR_RANGE = 6;
	localparam int ST_WR_REFERENCE_SOURCE_SELECT = 7;
	typedef enum logic [1:0] {
		CMSC_SELF = 2'b00,
		CMSC_FLL_INT = 2'b01,
		CMSC_BYP_EXT = 2'b10,
		CMSC_FLL_EXT = 2'b11
	} cmsc_mode_t;
	localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;
endpackage : cmsc_pkg

// ===== cmsc_once_bit.sv
`timescale 1ns/1ns
module cmsc_once_bit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic wr_val,
	output logic val_q,
	output logic done_q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			val_q <= 1'b0;
			done_q <= 1'b0;
		end else if (wr_en && !done_q) begin
			val_q <= wr_val;
			done_q <= 1'b1;
		end
	end

	a_once_hold: assert property (@(posedge pclk) disable iff (!presetn) // (R3)
		done_q |=> (val_q == $past(val_q)) && done_q)
		else $error("write-once bit changed after first write");
endmodule : cmsc_once_bit

// ===== cmsc_mode_seq.sv
`timescale 1ns/1ns
module cmsc_mode_seq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire cmsc_pkg::cmsc_mode_t req_mode,
	input wire logic ext_ready,
	input wire logic fll_locked,
	output cmsc_pkg::cmsc_mode_t active_q,
	output logic busy_q
);
	import cmsc_pkg::*;
	cmsc_mode_t target_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target_q <= CMSC_SELF;
		end else if (req_valid && !busy_q) begin
			target_q <= req_mode;
		end
	end
	// switch over once the new source is ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			active_q <= CMSC_SELF;
		end else if (req_valid && !busy_q) begin
			busy_q <= (req_mode != active_q);
		end else if (busy_q) begin
			unique case (target_q)
				CMSC_BYP_EXT: begin
					if (ext_ready) begin // (R10)
						active_q <= target_q;
						busy_q <= 1'b0;
					end
				end
				CMSC_FLL_EXT: begin
					if (ext_ready && fll_locked) begin
						active_q <= target_q;
						busy_q <= 1'b0;
					end
				end
				CMSC_FLL_INT: begin
					if (fll_locked) begin
						active_q <= target_q;
						busy_q <= 1'b0;
					end
				end
				CMSC_SELF: begin
					active_q <= target_q;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	a_bypass_wait: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
		(busy_q && target_q == CMSC_BYP_EXT && !ext_ready) |=> active_q == $past(active_q))
		else $error("bypass mode taken before external reference ready");
endmodule : cmsc_mode_seq

// ===== cmsc_testbench.sv
`timescale 1ns/1ns
module testbench;
	import cmsc_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic ext_rdy = 0;
	logic fll_lk = 0;
	logic gen_off = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, hgs, rhi, rss, grun, err;
	logic [6:0] lps;
	logic [1:0] amode;
	int failures = 0;
	int num_checks = 0;
	int m_g, m_r, m_s, m_mode, m_act, m_first, m_xlock;
	always #10 pclk = ~pclk;
	cmsc_clock_mode_select i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .external_reference_ready(ext_rdy),
		.fll_locked(fll_lk), .gen_off(gen_off), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.high_gain_select(hgs), .range_high(rhi), .loop_prescale(lps), .reference_source_select(rss),
		.active_mode(amode), .gen_running(grun));
	task automatic complete_run;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1) begin
			failures++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic do_reset;
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		m_g = 0;
		m_r = 0;
		m_s = 0;
		m_mode = 0;
		m_act = 0;
		m_first = 0;
		m_xlock = 0;
	endtask : do_reset
	task automatic mwrite(input logic [7:0] d);
		apb(1, CTRL_ONE_OFS, {24'($urandom()), d});
		if (m_first == 0) begin
			m_g = d[7];
			m_r = d[6];
			m_s = d[5];
			m_xlock = !d[4];
		end
		if (m_act == m_mode && !(m_xlock && d[4]))
			m_mode = d[4:3];
		m_first = 1;
	endtask : mwrite
	task automatic read_ctrl;
		apb(0, CTRL_ONE_OFS, 32'h0);
		check(rd, 32'(m_g * 128 + m_r * 64 + m_s * 32 + m_mode * 8));
		check(err, 1'b0);
	endtask : read_ctrl
	task automatic outs_mode;
		int n;
		n = 0;
		while (amode !== 2'(m_mode) && n < 20) begin
			@(posedge pclk);
			n++;
		end
		m_act = m_mode;
		check(amode, m_mode);
		check(hgs, m_g);
		check(rss, m_s);
		check(grun, !gen_off);
		check(rhi, (m_act >= 2) && m_r);
		check(lps, (m_act >= 2 && m_r == 0) ? PRESCALE_LOW : PRESCALE_HIGH);
	endtask : outs_mode
	initial begin
		void'($urandom(36));
		do_reset();
		read_ctrl();
		check(lps, PRESCALE_HIGH);
		$display("test reset values done");
		fll_lk <= 1;
		mwrite(8'ha8);
		outs_mode();
		mwrite(8'h58);
		repeat (5) @(posedge pclk);
		read_ctrl();
		apb(0, STATUS_OFS, 32'h0);
		check(rd[ST_XLOCK], m_xlock);
		check(rd[ST_WR_RANGE], 1'b1);
		outs_mode();
		apb(0, 12'h008, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		$display("test internal first write done");
		do_reset();
		fll_lk <= 0;
		mwrite(8'h10);
		repeat (10) @(posedge pclk);
		check(amode, 2'b00);
		apb(0, STATUS_OFS, 32'h0);
		check(rd[ST_BUSY], 1'b1);
		mwrite(8'h18);
		ext_rdy <= 1;
		outs_mode();
		read_ctrl();
		fll_lk <= 1;
		mwrite(8'hd8);
		outs_mode();
		read_ctrl();
		gen_off <= 1;
		repeat (3) @(posedge pclk);
		check(grun, 1'b0);
		read_ctrl();
		outs_mode();
		$display("test external modes done");
		complete_run();
	end
	initial begin
		#100000;
		failures++;
		complete_run();
	end
endmodule : testbench
